// [inc/regsup_pkg.sv]
package regsup_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 50;         // 20 MHz core clock
    localparam int BIAS_DELAY_NS   = 170000;     // 170 us start-up bias wait
    localparam int BIAS_CYC        = (BIAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_TIME_NS      = 750000;     // 750 us soft-start, 5 % to 95 %
    localparam int SS_START_PCT    = 5;
    localparam int SS_END_PCT      = 95;
    localparam int SS_FULL_PCT     = 100;
    localparam int SS_STEP_CYC     =
        SS_TIME_NS / ((SS_END_PCT - SS_START_PCT) * CLK_PERIOD_NS);
    localparam longint DEBOUNCE_NS = 30000000;   // 30 ms warm reset filter
    localparam int DEBOUNCE_CYC    = int'(DEBOUNCE_NS / CLK_PERIOD_NS);
    localparam longint RST_NS_PER_NF = 100000000; // 1 nF gives 100 ms
    localparam int CAP_UNITS_PER_NF  = 10;       // Cap code counts 0.1 nF steps
    localparam int RST_UNIT_CYC    =
        int'(RST_NS_PER_NF / (CAP_UNITS_PER_NF * CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PGOOD     = 4'h0; // power_good_status
    localparam logic [3:0] ADDR_DISCHARGE = 4'h1; // discharge_control
    localparam logic [3:0] ADDR_LINEAR    = 4'h2; // linear_voltage_control
    localparam logic [3:0] ADDR_CORE      = 4'h3; // core voltage code
    localparam logic [3:0] ADDR_STATUS    = 4'h4; // block state
    localparam logic [7:0] UNMAPPED_DATA  = 8'hff;

    localparam logic [2:0] DISCHARGE_RST  = 3'h0;
    localparam logic [5:0] LINEAR_RST     = 6'h03; // Both software enables set
    localparam int         LIN_EN_LSB     = 0;
    localparam int         LIN_VSEL_LSB   = 2;

    // ------------------------------------------------------------
    // Strap defaults
    // ------------------------------------------------------------
    localparam logic [7:0]  CORE_CODE_LO  = 8'h34; // 1.3 V in 25 mV steps
    localparam logic [7:0]  CORE_CODE_HI  = 8'h3e; // 1.55 V in 25 mV steps
    localparam logic [11:0] MEM_MV_LO     = 12'h708; // 1800 mV
    localparam logic [11:0] MEM_MV_HI     = 12'h9c4; // 2500 mV
    localparam logic [11:0] SYS_MV_LO     = 12'hbb8; // 3000 mV
    localparam logic [11:0] SYS_MV_HI     = 12'hce4; // 3300 mV

    // Rail index order in the status vectors
    localparam int RAIL_SYS  = 0;
    localparam int RAIL_MEM  = 1;
    localparam int RAIL_CORE = 2;
    localparam int RAIL_LIN1 = 3;

    typedef enum logic [3:0] {
        CONV_OFF  = 4'h1,
        CONV_BIAS = 4'h2,
        CONV_RAMP = 4'h4,
        CONV_RUN  = 4'h8
    } conv_state_t;

    typedef struct packed {
        conv_state_t [2:0]  st;        // Converter sequencers
        logic [2:0][11:0]   cnt;       // Bias / ramp step counters
        logic [2:0][6:0]    ramp;      // Internal ramp level, percent
        logic [2:0]         sw_en;     // Switching allowed
        logic [2:0]         sink_blk;  // Low-side sinking blocked
        logic [2:0]         dis_en;    // Discharge load on
        logic [1:0]         lin_on;    // Linear regulators on
        logic [4:0]         fault;     // Power-good faults
        logic [4:0]         blk;       // Faults hidden from interrupt
        logic               irq;
        logic               uv_lock;
        logic               hot;
        logic               bk_low;
        logic [2:0]         dis_ctrl;
        logic [5:0]         lin_ctrl;
        logic [7:0]         core_code;
        logic [2:0]         strap;
        logic               strap_taken;
        logic               warm_filt;
        logic [19:0]        deb_cnt;
        logic [23:0]        unit_cnt;
        logic [7:0]         cap_cnt;
        logic               rst_active;
        logic [7:0]         rdata;
    } state_t;

endpackage

// [src/regulator_supervisor_sequencer.sv]
`timescale 1ns/1ns

// Notes on behaviour
// - Wait bias delay before converter switching
// - Soft-start 5 to 95 percent in 750 us
// - No sinking until ramp reaches precharge
// - Discharge off at reset, per-converter bits
// - Discharge load on while converter disabled
// - Fault below margin, clear after hysteresis
// - Five power-good bits readable by software
// - Interrupt when any rail drops out
// - Disabled converter reports power good
// - Disabled linear regulator reports power good
// - One pin enables both linears, software gates
// - Undervoltage or overtemperature kills all rails
// - Undervoltage lockout with release hysteresis
// - Core default voltage from its strap
// - Memory default voltage from its strap
// - System default voltage from its strap
// - Each converter has own enable pin
// - Warm reset restores only core voltage
// - Warm reset input debounced internally
// - Reset low at power-up, backup low, stretched
// - Stretch delay scales with timing capacitor
// - Warm reset forces system reset low
// - Debounce rejects pulses under 30 ms
// - Faults seen at status read stop interrupting
module regulator_supervisor_sequencer #(
    parameter int DEB_CYC       = regsup_pkg::DEBOUNCE_CYC,
    parameter int RST_UNIT_CYCS = regsup_pkg::RST_UNIT_CYC
) (
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    // Register port
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    // Enables and straps
    input  wire logic            system_rail_enable,
    input  wire logic            memory_rail_enable,
    input  wire logic            core_rail_enable,
    input  wire logic            linear_regs_enable,
    input  wire logic            system_rail_strap,
    input  wire logic            memory_rail_strap,
    input  wire logic            core_rail_strap,
    // Analog comparator results
    input  wire logic            supply_below_supply_undervoltage_lock,
    input  wire logic            supply_above_release,
    input  wire logic            thermal_shutdown,
    input  wire logic            backup_clock_rail_low,
    input  wire logic            backup_clock_rail_ok,
    input  wire logic [4:0]      rail_below_fault,
    input  wire logic [4:0]      rail_recovered,
    input  wire logic [2:0][6:0] precharge_pct,
    input  wire logic [7:0]      reset_delay_cap,
    input  wire logic            warm_reset_in,
    // Converter controls
    output logic      [2:0]      conv_switch_en,
    output logic      [2:0]      conv_sink_block,
    output logic      [2:0][6:0] conv_ramp_pct,
    output logic      [2:0]      discharge_load_en,
    output logic      [1:0]      linear_reg_on,
    output logic      [3:0]      linear_vsel,
    output logic      [11:0]     system_rail_target_mv,
    output logic      [11:0]     memory_rail_target_mv,
    output logic      [7:0]      core_rail_code,
    output logic                 power_fault_irq,
    // Open-drain system reset
    input  wire logic            system_reset_out_n_i,
    output logic                 system_reset_out_n_o,
    output logic                 system_reset_out_n_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    regsup_pkg::state_t q; // Registered state
    regsup_pkg::state_t d; // Next state

    logic [2:0] en_pin;       // Enable pins as a vector
    logic       shutdown;     // Global power-down
    logic [2:0] conv_on;      // Converter allowed to run
    logic [4:0] mon;          // Comparator active per rail
    logic [7:0] core_default; // Strap default for core code
    logic       hold;         // Reason to keep reset low

    assign en_pin = {core_rail_enable, memory_rail_enable, system_rail_enable};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Whole block next state
    always_comb begin
        d = q;
        core_default = q.strap[regsup_pkg::RAIL_CORE] ? regsup_pkg::CORE_CODE_HI
            : regsup_pkg::CORE_CODE_LO;

        // Straps caught once after reset
        if (!q.strap_taken) begin
            d.strap       = {core_rail_strap, memory_rail_strap, system_rail_strap};
            d.strap_taken = 1'b1;
            d.core_code   = core_rail_strap ? regsup_pkg::CORE_CODE_HI
                : regsup_pkg::CORE_CODE_LO;
        end

        if (supply_below_supply_undervoltage_lock) begin
            d.uv_lock = 1'b1;
        end else if (supply_above_release) begin
            d.uv_lock = 1'b0;
        end
        d.hot = thermal_shutdown;
        shutdown = q.uv_lock | q.hot;

        // Backup rail comparator with hysteresis
        if (backup_clock_rail_low) begin
            d.bk_low = 1'b1;
        end else if (backup_clock_rail_ok) begin
            d.bk_low = 1'b0;
        end

        // Converter sequencers
        for (int i = 0; i < 3; i++) begin
            conv_on[i] = en_pin[i] & ~shutdown;
            unique case (q.st[i])
                regsup_pkg::CONV_OFF: begin
                    // Start bias wait on enable
                    if (conv_on[i]) begin
                        d.st[i]  = regsup_pkg::CONV_BIAS;
                        d.cnt[i] = 12'h000;
                    end
                end
                regsup_pkg::CONV_BIAS: begin
                    if (!conv_on[i]) begin
                        d.st[i] = regsup_pkg::CONV_OFF;
                    end else if (q.cnt[i] == 12'(regsup_pkg::BIAS_CYC - 1)) begin
                        d.st[i]   = regsup_pkg::CONV_RAMP;
                        d.cnt[i]  = 12'h000;
                        d.ramp[i] = 7'(regsup_pkg::SS_START_PCT);
                    end else begin
                        d.cnt[i] = q.cnt[i] + 12'h001;
                    end
                end
                regsup_pkg::CONV_RAMP: begin
                    if (!conv_on[i]) begin
                        d.st[i] = regsup_pkg::CONV_OFF;
                    end else if (q.cnt[i] == 12'(regsup_pkg::SS_STEP_CYC - 1)) begin
                        d.cnt[i] = 12'h000;
                        if (q.ramp[i] == 7'(regsup_pkg::SS_END_PCT - 1)) begin
                            d.st[i]   = regsup_pkg::CONV_RUN;
                            d.ramp[i] = 7'(regsup_pkg::SS_FULL_PCT);
                        end else begin
                            d.ramp[i] = q.ramp[i] + 7'h01;
                        end
                    end else begin
                        d.cnt[i] = q.cnt[i] + 12'h001;
                    end
                end
                regsup_pkg::CONV_RUN: begin
                    // Regulating until disabled
                    if (!conv_on[i]) begin
                        d.st[i] = regsup_pkg::CONV_OFF;
                    end
                end
                default: begin
                    // Illegal code recovers to off
                    d.st[i] = regsup_pkg::CONV_OFF;
                end
            endcase
            if (d.st[i] == regsup_pkg::CONV_OFF) begin
                d.ramp[i] = 7'h00;
            end
            d.sw_en[i] = (d.st[i] == regsup_pkg::CONV_RAMP)
                | (d.st[i] == regsup_pkg::CONV_RUN);
            d.sink_blk[i] = (d.st[i] == regsup_pkg::CONV_RAMP)
                & (d.ramp[i] < precharge_pct[i]);
            // load on while converter is off and its dis_ctrl bit is set
            d.dis_en[i] = q.dis_ctrl[i] & (d.st[i] == regsup_pkg::CONV_OFF);
        end

        d.lin_on = {2{linear_regs_enable & ~shutdown}}
                 & q.lin_ctrl[regsup_pkg::LIN_EN_LSB +: 2];

        // Comparators only watch running rails
        for (int r = 0; r < 5; r++) begin
            if (r < 3) begin
                mon[r] = (q.st[r] == regsup_pkg::CONV_RUN);
            end else begin
                mon[r] = q.lin_on[r - regsup_pkg::RAIL_LIN1];
            end
            if (!mon[r]) begin
                d.fault[r] = 1'b0;
            // set below margin, clear on recovery
            end else if (rail_below_fault[r]) begin
                d.fault[r] = 1'b1;
            end else if (rail_recovered[r]) begin
                d.fault[r] = 1'b0;
            end
        end

        // hide faults present at status read
        d.blk = q.blk & d.fault;
        if (reg_rd && reg_addr == regsup_pkg::ADDR_PGOOD) begin
            d.blk = d.blk | (q.fault & d.fault);
        end
        d.irq = |(q.fault & ~q.blk);

        // level must hold for full filter time
        if (warm_reset_in != q.warm_filt) begin
            if (q.deb_cnt == 20'(DEB_CYC - 1)) begin
                d.warm_filt = warm_reset_in;
                d.deb_cnt   = 20'h00000;
            end else begin
                d.deb_cnt = q.deb_cnt + 20'h00001;
            end
        end else begin
            d.deb_cnt = 20'h00000;
        end

        hold = q.bk_low | q.warm_filt;
        if (hold) begin
            d.rst_active = 1'b1;
            d.unit_cnt   = 24'h000000;
            d.cap_cnt    = 8'h00;
        end else if (q.rst_active) begin
            if (q.cap_cnt >= reset_delay_cap) begin
                d.rst_active = 1'b0;
            end else if (q.unit_cnt == 24'(RST_UNIT_CYCS - 1)) begin
                d.unit_cnt = 24'h000000;
                d.cap_cnt  = q.cap_cnt + 8'h01;
            end else begin
                d.unit_cnt = q.unit_cnt + 24'h000001;
            end
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                regsup_pkg::ADDR_DISCHARGE: d.dis_ctrl  = reg_wdata[2:0];
                regsup_pkg::ADDR_LINEAR:    d.lin_ctrl  = reg_wdata[5:0];
                regsup_pkg::ADDR_CORE:      d.core_code = reg_wdata;
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
        // warm reset reloads core code only
        if (d.warm_filt && !q.warm_filt) begin
            d.core_code = core_default;
        end

        // Read data for one cycle only
        d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                // five power-good bits, 1 = fault
                regsup_pkg::ADDR_PGOOD:     d.rdata = {3'h0, q.fault};
                regsup_pkg::ADDR_DISCHARGE: d.rdata = {5'h00, q.dis_ctrl};
                regsup_pkg::ADDR_LINEAR:    d.rdata = {2'h0, q.lin_ctrl};
                regsup_pkg::ADDR_CORE:      d.rdata = q.core_code;
                regsup_pkg::ADDR_STATUS:    d.rdata = {1'b0, q.sw_en, q.warm_filt,
                    system_reset_out_n_i, q.hot, q.uv_lock};
                default:                    d.rdata = regsup_pkg::UNMAPPED_DATA;
            endcase
        end

        // Synchronous reset values
        if (sys_rst) begin
            d = '0;
            d.st = '{default: regsup_pkg::CONV_OFF};
            d.dis_ctrl   = regsup_pkg::DISCHARGE_RST;
            d.lin_ctrl   = regsup_pkg::LINEAR_RST;
            d.core_code  = regsup_pkg::CORE_CODE_LO;
            d.uv_lock    = 1'b1;   // Assume low supply until proven
            d.rst_active = 1'b1;   // Power-up reset stretch
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // One register stage
    always_ff @(posedge core_clk) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = q.rdata;
    assign conv_switch_en = q.sw_en;
    assign conv_sink_block = q.sink_blk;
    assign conv_ramp_pct = q.ramp;
    assign discharge_load_en = q.dis_en;
    assign linear_reg_on = q.lin_on;
    assign linear_vsel = q.lin_ctrl[regsup_pkg::LIN_VSEL_LSB +: 4];
    assign system_rail_target_mv = q.strap[regsup_pkg::RAIL_SYS] ? regsup_pkg::SYS_MV_HI
        : regsup_pkg::SYS_MV_LO;
    assign memory_rail_target_mv = q.strap[regsup_pkg::RAIL_MEM] ? regsup_pkg::MEM_MV_HI
        : regsup_pkg::MEM_MV_LO;
    assign core_rail_code = q.core_code;
    assign power_fault_irq = q.irq;
    // Open drain: only ever pulls low
    assign system_reset_out_n_o = 1'b0;
    assign system_reset_out_n_oe = q.rst_active;

endmodule

// [sim/regsup_checker_properties.sv]
`timescale 1ns/1ns

// ----------------------------------------
// Port checker for the supervisor
// ----------------------------------------
module regsup_checker #(
    parameter int DEB_CYC       = 8,
    parameter int RST_UNIT_CYCS = 4
) (
    input wire logic            core_clk,
    input wire logic            sys_rst,
    input wire logic            core_rail_enable,
    input wire logic            core_rail_strap,
    input wire logic            supply_below_supply_undervoltage_lock,
    input wire logic            thermal_shutdown,
    input wire logic            backup_clock_rail_low,
    input wire logic [4:0]      rail_below_fault,
    input wire logic            warm_reset_in,
    input wire logic [2:0]      conv_switch_en,
    input wire logic [2:0]      conv_sink_block,
    input wire logic [2:0][6:0] conv_ramp_pct,
    input wire logic [2:0]      discharge_load_en,
    input wire logic [1:0]      linear_reg_on,
    input wire logic [7:0]      core_rail_code,
    input wire logic            power_fault_irq,
    input wire logic            system_reset_out_n_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Cycles enabled without switching
    logic [15:0] bias_q;
    logic [15:0] bias_d;
    always_comb bias_d = (core_rail_enable && !conv_switch_en[2]) ? bias_q + 16'd1 : 16'd0;
    always_ff @(posedge core_clk) bias_q <= sys_rst ? 16'd0 : bias_d;

    bias_wait_a: assert property ($rose(conv_switch_en[2]) |->
        bias_q >= 16'(regsup_pkg::BIAS_CYC - 1)) else $error("switching before bias wait");
    ramp_start_a: assert property ($rose(conv_switch_en[0]) |->
        conv_ramp_pct[0] == 7'd5) else $error("ramp not started at five");
    run_no_block_a: assert property (conv_ramp_pct[1] == 7'd100 |->
        !conv_sink_block[1]) else $error("sinking still blocked in run");
    discharge_rst_a: assert property ($fell(sys_rst) |->
        discharge_load_en == 3'h0) else $error("discharge on after reset");
    discharge_off_a: assert property ((discharge_load_en & conv_switch_en) == 3'h0)
        else $error("discharge on while running");
    fault_irq_a: assert property ($rose(power_fault_irq) |-> $past(|rail_below_fault, 1) ||
        $past(|rail_below_fault, 2) || $past(|rail_below_fault, 3)) else $error("stray irq");
    idle_no_irq_a: assert property ((conv_switch_en == 3'h0 && linear_reg_on == 2'h0) [*4]
        |-> !power_fault_irq) else $error("irq with all rails off");
    thermal_off_a: assert property (thermal_shutdown |-> ##[1:3]
        (conv_switch_en == 3'h0 && linear_reg_on == 2'h0)) else $error("rails on when hot");
    uv_off_a: assert property (supply_below_supply_undervoltage_lock |-> ##[1:3]
        (conv_switch_en == 3'h0 && linear_reg_on == 2'h0)) else $error("rails on in lockout");
    strap_core_a: assert property ($fell(sys_rst) |-> ##3 core_rail_code ==
        (core_rail_strap ? regsup_pkg::CORE_CODE_HI : regsup_pkg::CORE_CODE_LO))
        else $error("core code not from strap");
    backup_rst_a: assert property (backup_clock_rail_low |-> ##[1:3]
        system_reset_out_n_oe) else $error("no reset on backup low");
    warm_rst_a: assert property (warm_reset_in [*8] |-> ##[1:4]
        system_reset_out_n_oe) else $error("no reset on warm");
endmodule

bind regulator_supervisor_sequencer regsup_checker #(
    .DEB_CYC(DEB_CYC), .RST_UNIT_CYCS(RST_UNIT_CYCS)) chk (.*);

// [sim/host_model.sv]
`timescale 1ns/1ns

// ----------------------------------------
// Host side: drives enables, sees reset
// ----------------------------------------
module host_model (
    input  wire logic core_clk,
    input  wire logic [3:0] want_on,  // Bench request {linear, core, memory, system}
    input  wire logic dev_pull,       // Device pin driver level
    input  wire logic dev_pull_en,    // Device pulling the pin
    output logic      rst_n_pin,      // Resolved open-drain reset level
    output logic [3:0] enables        // Enable pins to the device
);
    // Pull-up when released
    assign rst_n_pin = dev_pull_en ? dev_pull : 1'b1;
    initial enables = 4'h0;
    // one level per pin
    // Pins change after an edge
    always @(posedge core_clk) begin
        enables <= want_on;
    end
endmodule

// [sim/test_regulator_supervisor_sequencer.sv]
`timescale 1ns/1ns

module test_regulator_supervisor_sequencer;
    // ----------------------------------------
    // Stimulus, outputs, bookkeeping
    // ----------------------------------------
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, warm = 1'b0;
    logic uv_lo = 1'b0, uv_ok = 1'b0, hot = 1'b0, bk_lo = 1'b0, bk_ok = 1'b1;
    logic [3:0] reg_addr = 4'h0, want_on = 4'h0, vsel, en;
    logic [7:0] reg_wdata = 8'h00, cap = 8'h03, rdata, code;
    logic [4:0] below = 5'h00, back = 5'h00;
    logic [2:0] strap = 3'h5;  // Board straps {core, memory, system}, fixed
    logic [2:0][6:0] pre = '0, ramp;
    logic [2:0] sw_en, sink, dis;
    logic [1:0] lin_on;
    logic [11:0] sys_mv, mem_mv;
    logic irq, pin_o, pin_oe, rst_n_pin;
    int num_errors = 0, total_checks = 0, n;
    logic [15:0] seed = 16'hdaf7;  // Fixed start for repeatable runs
    localparam int UNIT = 4;
    localparam logic [3:0] pg_adr = regsup_pkg::ADDR_PGOOD;

    regulator_supervisor_sequencer #(.DEB_CYC(8), .RST_UNIT_CYCS(UNIT)) uut (
        .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata),
        .system_rail_enable(en[0]),
        .memory_rail_enable(en[1]), .core_rail_enable(en[2]), .linear_regs_enable(en[3]),
        .system_rail_strap(strap[0]), .memory_rail_strap(strap[1]),
        .core_rail_strap(strap[2]), .supply_below_supply_undervoltage_lock(uv_lo), .supply_above_release(uv_ok),
        .thermal_shutdown(hot), .backup_clock_rail_low(bk_lo), .backup_clock_rail_ok(bk_ok),
        .rail_below_fault(below), .rail_recovered(back), .precharge_pct(pre),
        .reset_delay_cap(cap), .warm_reset_in(warm), .conv_switch_en(sw_en),
        .conv_sink_block(sink), .conv_ramp_pct(ramp), .discharge_load_en(dis),
        .linear_reg_on(lin_on), .linear_vsel(vsel), .system_rail_target_mv(sys_mv),
        .memory_rail_target_mv(mem_mv), .core_rail_code(code), .power_fault_irq(irq),
        .system_reset_out_n_i(rst_n_pin), .system_reset_out_n_o(pin_o),
        .system_reset_out_n_oe(pin_oe));
    host_model host (.core_clk, .want_on, .dev_pull(pin_o),
        .dev_pull_en(pin_oe), .rst_n_pin(rst_n_pin), .enables(en));

    initial forever #25 core_clk = ~core_clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Sample after outputs settle
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand one cycle after strobe
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Bias plus ramp take about 18340
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        close_out;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        tick(3);
        chk("reset_pin", rst_n_pin, 0);
        rd("dis", regsup_pkg::ADDR_DISCHARGE, 8'(regsup_pkg::DISCHARGE_RST));
        rd("linear", regsup_pkg::ADDR_LINEAR, 8'(regsup_pkg::LINEAR_RST));
        rd("core", regsup_pkg::ADDR_CORE, regsup_pkg::CORE_CODE_HI);
        chk("mem_mv", mem_mv, regsup_pkg::MEM_MV_LO);
        chk("sys_mv", sys_mv, regsup_pkg::SYS_MV_HI);
        rd("unmapped", 4'hf, regsup_pkg::UNMAPPED_DATA);
        rd("pg_idle", pg_adr, 8'h00);
        $display("test reset done");
        for (int c = 2; c <= 6; c += 4) begin
            tick(30);
            @(posedge core_clk);
            cap <= 8'(c);
            {bk_lo, bk_ok} <= 2'b10;
            tick(4);
            chk("backup_low", rst_n_pin, 0);
            @(posedge core_clk);
            {bk_lo, bk_ok} <= 2'b01;
            n = 0;
            while (rst_n_pin !== 1'b1 && n < 200) begin tick(1); n++; end
            chk("stretch", n >= c * UNIT && n <= c * UNIT + 4, 1);
        end
        $display("test stretch done");
        @(posedge core_clk);
        uv_ok <= 1'b1;
        seed = lfsr(seed);
        wr(regsup_pkg::ADDR_LINEAR, {seed[3:0], 2'b11});
        want_on <= 4'h8;
        tick(4);
        chk("lin_on", lin_on, 2'b11);
        chk("vsel", vsel, seed[3:0]);
        wr(regsup_pkg::ADDR_LINEAR, {seed[3:0], 2'b10});
        wr(regsup_pkg::ADDR_DISCHARGE, 8'h07);
        tick(2);
        chk("lin_sw_off", lin_on, 2'b10);
        chk("dis_idle", dis, 3'h7);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            pre[i] <= 7'(seed[5:0]);
        end
        want_on <= 4'hf;
        n = 0;
        while (sw_en !== 3'h7 && n < 4000) begin tick(1); n++; end
        chk("bias", n >= regsup_pkg::BIAS_CYC - 2 && n <= regsup_pkg::BIAS_CYC + 4, 1);
        chk("dis_run", dis, 3'h0);
        for (int i = 0; i < 3; i++) begin
            chk("ramp_start", ramp[i], 7'd5);
            chk("sink_block", sink[i], pre[i] > 7'd5);
        end
        n = 0;
        while (ramp[2] !== 7'd100 && n < 20000) begin tick(1); n++; end
        chk("ramp_time", n >= regsup_pkg::SS_STEP_CYC * 89 &&
            n <= regsup_pkg::SS_STEP_CYC * 91, 1);
        chk("sink_run", sink, 3'h0);
        $display("test start-up done");
        @(posedge core_clk);
        below <= 5'h02;
        tick(4);
        chk("irq", irq, 1);
        rd("pg", pg_adr, 8'h02);
        tick(2);
        chk("irq_hidden", irq, 0);
        below <= 5'h00;
        rd("pg_held", pg_adr, 8'h02);
        back <= 5'h02;
        tick(2);
        back <= 5'h00;
        rd("pg_clr", pg_adr, 8'h00);
        below <= 5'h18;
        tick(4);
        chk("irq_lin", irq, 1);
        rd("pg_lin", pg_adr, 8'h10);
        below <= 5'h02;
        back <= 5'h18;
        want_on <= 4'hd;
        tick(4);
        rd("pg_off", pg_adr, 8'h00);
        chk("dis_off", dis, 3'h2);
        {below, back} <= 10'h000;
        hot <= 1'b1;
        tick(4);
        chk("hot_sw", sw_en, 3'h0);
        chk("hot_lin", lin_on, 2'h0);
        chk("hot_dis", dis, 3'h7);
        hot <= 1'b0;
        $display("test faults done");
        wr(regsup_pkg::ADDR_CORE, 8'h20);
        warm <= 1'b1;
        tick(3);
        warm <= 1'b0;
        tick(10);
        chk("gl_code", code, 8'h20);
        chk("gl_pin", pin_oe, 0);
        warm <= 1'b1;
        tick(12);
        chk("warm_code", code, regsup_pkg::CORE_CODE_HI);
        chk("warm_pin", rst_n_pin, 0);
        warm <= 1'b0;
        rd("warm_keep", regsup_pkg::ADDR_DISCHARGE, 8'h07);
        {uv_lo, uv_ok} <= 2'b10;
        tick(4);
        chk("uv_lin", lin_on, 2'h0);
        $display("test warm done");
        close_out;
    end
endmodule
